// *** rtl/hbcw_regs.sv ***
/*
  Host bus configuration and wait-state register bank with the cycle
  controller that applies the wait settings and response enables.
  Assumes register strobes, cycle starts and decode inputs come from
  host bus logic on the same REF_CLK, so none of them is synchronised.
*/
`timescale 1ns/1ps
// Operation
// - Scratch byte at 3C, read/write, no effect
// - Byte at 3D reads 01
// - Byte at 3E reads FF
// - Byte at 3F reads 01
// - Global bit delays cycle start one clock
// - Total waits are type waits plus global
// - Memory-write bit adds one clock on writes
// - MMIO code gives 1-4 read, 0-3 write
// - I/O code gives 1-4 wait clocks
// - ISA bits select 16-bit memory and I/O
// - Bit 0 selects legacy or extended decode
// - Aperture select, ignored when extended disabled
// - Bit 6 gates graphics memory response
// - Bit 7 gates memory-mapped I/O response
module hbcw_regs
  import hbcw_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RST,
  input  wire logic              CFG_WR,
  input  wire logic              CFG_RD,
  input  wire logic [7:0]        CFG_ADDR,
  input  wire logic              EXT_WR,
  input  wire logic              EXT_RD,
  input  wire logic [7:0]        EXT_INDEX,
  input  wire logic [7:0]        WR_DATA,
  output logic      [7:0]        RD_DATA,
  output logic                   RD_VALID,
  input  wire logic              CYC_START,
  input  hbcw_pkg::hbcw_cyc_t    CYC_TYPE,
  input  wire logic              CYC_WRITE,
  input  wire logic [31:0]       HOST_ADDR,
  input  wire logic [31:0]       MEM_BASE_ADDR,
  input  wire logic [1:0]        GFX_MAP_MODE,
  input  wire logic              MMIO_DECODE,
  output logic                   CYC_GO,
  output logic                   CYC_BUSY,
  output logic                   SLAVE_READY_OUT_N,
  output logic                   MEM_CLAIM,
  output logic                   MMIO_CLAIM,
  output logic                   EXT_MAP_EN,
  output logic                   ISA_MEM16,
  output logic                   ISA_IO16
);
  import hbcw_pkg::*;

  logic [7:0]        irq_route_r;
  logic [7:0]        lb_wait_r;
  logic [7:0]        mem_map_r;
  logic [7:0]        isa_width_r;
  logic [7:0]        rd_data_r;
  logic              rd_valid_r;
  logic [7:0]        rd_data_nxt;
  hbcw_state_t       state_r;
  logic              go_r;
  logic              mem_claim_r;
  logic              mmio_claim_r;
  logic [WAIT_W-1:0] waits_r;
  logic [WAIT_W-1:0] waits_nxt;
  logic              mem_hit;
  logic              accept;

  hbcw_wait_if w ();

  hbcw_wait_timer u_timer (
    .clk (REF_CLK),
    .rst (RST),
    .w   (w.timer)
  );

  // Aperture mask per select code; reserved codes give no window
  function automatic logic [31:0] aper_mask(input logic [2:0] code);
    case (code)
      3'h0:    aper_mask = APER_256K;
      3'h1:    aper_mask = APER_512K;
      3'h2:    aper_mask = APER_1M;
      3'h3:    aper_mask = APER_2M;
      3'h4:    aper_mask = APER_4M;
      default: aper_mask = '0;
    endcase
  endfunction

  // Address lies in the window of given base and size mask
  function automatic logic in_window(input logic [31:0] addr,
                                     input logic [31:0] base,
                                     input logic [31:0] mask);
    in_window = ((addr & ~mask) == (base & ~mask));
  endfunction

  // Legacy window as set by the graphics controller map mode
  function automatic logic legacy_hit(input logic [31:0] addr,
                                      input logic [1:0]  mode);
    case (mode)
      2'h0:    legacy_hit = in_window(addr, LEG_A0000, LEG_M128K);
      2'h1:    legacy_hit = in_window(addr, LEG_A0000, LEG_M64K);
      2'h2:    legacy_hit = in_window(addr, LEG_B0000, LEG_M32K);
      default: legacy_hit = in_window(addr, LEG_B8000, LEG_M32K);
    endcase
  endfunction

  // Wait clocks for one cycle, before the global extra clock
  function automatic logic [WAIT_W-1:0] type_waits(input hbcw_cyc_t t,
                                                   input logic      wr,
                                                   input logic [7:0] lb);
    case (t)
      HBCW_CYC_IO:
        type_waits = {1'b0, lb[LB_IO_LSB+:2]} + WAIT_ONE;
      HBCW_CYC_MMIO:
        type_waits = wr ? {1'b0, lb[LB_MMIO_LSB+:2]}
                        : {1'b0, lb[LB_MMIO_LSB+:2]} + WAIT_ONE;
      default:
        type_waits = {2'b00, wr & lb[LB_MEMWR_BIT]};
    endcase
  endfunction

  // Graphics memory decode: legacy windows unless extended mapping
  always_comb begin
    if (mem_map_r[MAP_EXT_BIT]) begin
      mem_hit = (aper_mask(mem_map_r[MAP_APER_LSB+:3]) != '0) &&
                in_window(HOST_ADDR, MEM_BASE_ADDR,
                          aper_mask(mem_map_r[MAP_APER_LSB+:3]));
    end else begin
      mem_hit = legacy_hit(HOST_ADDR, GFX_MAP_MODE);
    end
  end

  // A memory or MMIO cycle is ours only when its response enable is set; I/O cycles are always taken
  always_comb begin
    case (CYC_TYPE)
      HBCW_CYC_IO:   accept = 1'b1;
      HBCW_CYC_MMIO: accept = MMIO_DECODE & mem_map_r[MAP_MMIO_EN];
      HBCW_CYC_MEM:  accept = mem_hit & mem_map_r[MAP_MEM_EN];
      default:       accept = 1'b0;
    endcase
  end

  assign waits_nxt = type_waits(CYC_TYPE, CYC_WRITE,
                                lb_wait_r);

  // Configuration space scratch byte; the read-only bytes take no write
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      irq_route_r <= IRQ_ROUTE_RST;
    end else if (CFG_WR && CFG_ADDR == CFG_IRQ_ROUTE) begin
      irq_route_r <= WR_DATA;
    end
  end

  // Extended registers; masks drop writes to reserved bits
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lb_wait_r   <= LB_WAIT_RST;
      mem_map_r   <= MEM_MAP_RST;
      isa_width_r <= ISA_WIDTH_RST;
    end else if (EXT_WR) begin
      case (EXT_INDEX)
        IDX_LB_WAIT:   lb_wait_r   <= WR_DATA & LB_WAIT_MASK;
        IDX_MEM_MAP:   mem_map_r   <= WR_DATA & MEM_MAP_MASK;
        IDX_ISA_WIDTH: isa_width_r <= WR_DATA & ISA_WIDTH_MASK;
        default:       ;
      endcase
    end
  end

  // Read mux; unmapped offsets and indices read zero
  always_comb begin
    rd_data_nxt = '0;
    if (CFG_RD) begin
      case (CFG_ADDR)
        CFG_IRQ_ROUTE: rd_data_nxt = irq_route_r;
        CFG_IRQ_PIN:   rd_data_nxt = IRQ_PIN_VAL;
        CFG_MIN_GNT:   rd_data_nxt = MIN_GNT_VAL;
        CFG_MAX_LAT:   rd_data_nxt = MAX_LAT_VAL;
        default:       rd_data_nxt = '0;
      endcase
    end else if (EXT_RD) begin
      case (EXT_INDEX)
        IDX_LB_WAIT:   rd_data_nxt = lb_wait_r;
        IDX_MEM_MAP:   rd_data_nxt = mem_map_r;
        IDX_ISA_WIDTH: rd_data_nxt = isa_width_r;
        default:       rd_data_nxt = '0;
      endcase
    end
  end

  // Read data is registered so the host sees a clean byte
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
    end else begin
      rd_valid_r <= CFG_RD | EXT_RD;
      if (CFG_RD || EXT_RD) begin
        rd_data_r <= rd_data_nxt;
      end
    end
  end

  // Cycle controller; starts during a cycle in flight are refused,
  // the host bus never overlaps cycles to one slave
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      state_r      <= ST_IDLE;
      go_r         <= 1'b0;
      waits_r      <= '0;
      mem_claim_r  <= 1'b0;
      mmio_claim_r <= 1'b0;
    end else begin
      go_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (CYC_START && accept) begin
            waits_r      <= waits_nxt;
            mem_claim_r  <= (CYC_TYPE == HBCW_CYC_MEM);
            mmio_claim_r <= (CYC_TYPE == HBCW_CYC_MMIO);
            if (lb_wait_r[LB_GLOBAL_BIT]) begin
              state_r <= ST_DELAY;
            end else begin
              go_r    <= 1'b1;
              state_r <= ST_RUN;
            end
          end
        end
        ST_DELAY: begin
          go_r    <= 1'b1;
          state_r <= ST_RUN;
        end
        ST_RUN: begin
          if (w.ready) begin
            state_r      <= ST_IDLE;
            mem_claim_r  <= 1'b0;
            mmio_claim_r <= 1'b0;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Timer starts on the internal start strobe
  assign w.load  = go_r;
  assign w.waits = waits_r;

  assign RD_DATA           = rd_data_r;
  assign RD_VALID          = rd_valid_r;
  assign CYC_GO            = go_r;
  assign CYC_BUSY          = (state_r != ST_IDLE);
  assign SLAVE_READY_OUT_N = ~w.ready;
  assign MEM_CLAIM         = mem_claim_r;
  assign MMIO_CLAIM        = mmio_claim_r;
  assign EXT_MAP_EN        = mem_map_r[MAP_EXT_BIT];
  assign ISA_MEM16         = isa_width_r[ISA_MEM16_BIT];
  assign ISA_IO16          = isa_width_r[ISA_IO16_BIT];

  // Checking helpers: start-to-ready count and its expected value
  logic [3:0] lat_r;
  logic [3:0] exp_r;
  logic       take;
  logic       leg_hit;
  assign take = (state_r == ST_IDLE) && CYC_START && accept;
  // Legacy decode as a plain signal so the check can look one clock back
  assign leg_hit = legacy_hit(HOST_ADDR, GFX_MAP_MODE);
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      lat_r <= '0;
      exp_r <= '0;
    end else if (take) begin
      lat_r <= 4'h1;
      exp_r <= 4'h2 + {3'b000, lb_wait_r[LB_GLOBAL_BIT]} +
               {1'b0, waits_nxt};
    end else if (lat_r != '0) begin
      lat_r <= lat_r + 4'h1;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_delayed_go;
    !go_r ##1 go_r;
  endsequence

  chk_irq_pin_val: assert property (
    CFG_RD && CFG_ADDR == CFG_IRQ_PIN |=> RD_DATA == IRQ_PIN_VAL)
    else $error("interrupt pin byte wrong");
  chk_min_gnt_val: assert property (
    CFG_RD && CFG_ADDR == CFG_MIN_GNT |=> RD_DATA == MIN_GNT_VAL)
    else $error("minimum grant byte wrong");
  chk_max_lat_val: assert property (
    CFG_RD && CFG_ADDR == CFG_MAX_LAT |=> RD_DATA == MAX_LAT_VAL)
    else $error("maximum latency byte wrong");
  chk_scratch_round_trip: assert property (
    CFG_WR && !CFG_RD && !EXT_RD && CFG_ADDR == CFG_IRQ_ROUTE ##1
    CFG_RD && CFG_ADDR == CFG_IRQ_ROUTE && !CFG_WR
    |=> RD_DATA == $past(WR_DATA, 2))
    else $error("scratch byte did not read back");
  chk_global_delay: assert property (
    take && lb_wait_r[LB_GLOBAL_BIT] |=> s_delayed_go)
    else $error("start strobe not delayed by one clock");
  chk_no_delay: assert property (
    take && !lb_wait_r[LB_GLOBAL_BIT] |=> go_r)
    else $error("start strobe delayed with global bit clear");
  chk_total_waits: assert property (
    lat_r != '0 && !SLAVE_READY_OUT_N |-> lat_r == exp_r)
    else $error("ready came after the wrong number of clocks");
  chk_ready_bound: assert property (
    take |-> ##[2:7] !SLAVE_READY_OUT_N)
    else $error("ready missing within seven clocks");
  chk_mem_gate: assert property (
    $rose(MEM_CLAIM) |-> $past(mem_map_r[MAP_MEM_EN]))
    else $error("graphics memory claimed while disabled");
  chk_mmio_gate: assert property (
    CYC_START && !CYC_BUSY && CYC_TYPE == HBCW_CYC_MMIO &&
    !mem_map_r[MAP_MMIO_EN] |=> !CYC_BUSY)
    else $error("mapped I/O answered while disabled");
  chk_legacy_decode: assert property (
    CYC_START && !CYC_BUSY && CYC_TYPE == HBCW_CYC_MEM &&
    mem_map_r[MAP_MEM_EN] && !mem_map_r[MAP_EXT_BIT]
    |=> MEM_CLAIM == $past(leg_hit))
    else $error("legacy decode wrong or aperture not ignored");
  chk_resv_zero: assert property (
    EXT_RD && !CFG_RD && EXT_INDEX == IDX_LB_WAIT
    |=> RD_DATA[1] == 1'b0 && RD_DATA[3] == 1'b0)
    else $error("reserved bit read as one");
  chk_isa_width: assert property (
    EXT_WR && EXT_INDEX == IDX_ISA_WIDTH
    |=> ISA_MEM16 == $past(WR_DATA[ISA_MEM16_BIT]))
    else $error("memory width bit not taken");
  chk_rd_valid: assert property (
    CFG_RD || EXT_RD |=> RD_VALID)
    else $error("read strobe gave no valid byte");
  chk_idle_quiet: assert property (
    !CYC_BUSY |-> SLAVE_READY_OUT_N)
    else $error("ready driven with no cycle in flight");
endmodule

// *** pkg/hbcw_pkg.sv ***
/*
  Constants, field layouts and types for the host bus configuration and
  wait-state register bank. Assumes one 40 MHz host-side clock and a
  byte-wide register port for both configuration and extended space.
*/
package hbcw_pkg;
  // Configuration space byte offsets
  localparam logic [7:0] CFG_IRQ_ROUTE = 8'h3c;
  localparam logic [7:0] CFG_IRQ_PIN   = 8'h3d;
  localparam logic [7:0] CFG_MIN_GNT   = 8'h3e;
  localparam logic [7:0] CFG_MAX_LAT   = 8'h3f;
  // Extended index port indices
  localparam logic [7:0] IDX_LB_WAIT   = 8'h10;
  localparam logic [7:0] IDX_ISA_WIDTH = 8'h12;
  localparam logic [7:0] IDX_MEM_MAP   = 8'h14;
  // Read-only configuration values
  localparam logic [7:0] IRQ_PIN_VAL   = 8'h01;
  localparam logic [7:0] MIN_GNT_VAL   = 8'hff;
  localparam logic [7:0] MAX_LAT_VAL   = 8'h01;
  // Reset values
  localparam logic [7:0] IRQ_ROUTE_RST = 8'h00;
  localparam logic [7:0] LB_WAIT_RST   = 8'hf5;
  localparam logic [7:0] MEM_MAP_RST   = 8'h40;
  localparam logic [7:0] ISA_WIDTH_RST = 8'h00;
  // Writable bit masks; all other bits are reserved and read zero
  localparam logic [7:0] LB_WAIT_MASK   = 8'hf5;
  localparam logic [7:0] MEM_MAP_MASK   = 8'hdd;
  localparam logic [7:0] ISA_WIDTH_MASK = 8'hc0;
  // Field positions
  localparam int LB_GLOBAL_BIT = 0;
  localparam int LB_MEMWR_BIT  = 2;
  localparam int LB_MMIO_LSB   = 4;
  localparam int LB_IO_LSB     = 6;
  localparam int MAP_EXT_BIT   = 0;
  localparam int MAP_APER_LSB  = 2;
  localparam int MAP_MEM_EN    = 6;
  localparam int MAP_MMIO_EN   = 7;
  localparam int ISA_IO16_BIT  = 6;
  localparam int ISA_MEM16_BIT = 7;
  // Aperture masks by select code (low address bits inside the window)
  localparam logic [31:0] APER_256K = 32'h0003ffff;
  localparam logic [31:0] APER_512K = 32'h0007ffff;
  localparam logic [31:0] APER_1M   = 32'h000fffff;
  localparam logic [31:0] APER_2M   = 32'h001fffff;
  localparam logic [31:0] APER_4M   = 32'h003fffff;
  // Legacy windows: base and mask per graphics-controller map mode
  localparam logic [31:0] LEG_A0000 = 32'h000a0000;
  localparam logic [31:0] LEG_B0000 = 32'h000b0000;
  localparam logic [31:0] LEG_B8000 = 32'h000b8000;
  localparam logic [31:0] LEG_M128K = 32'h0001ffff;
  localparam logic [31:0] LEG_M64K  = 32'h0000ffff;
  localparam logic [31:0] LEG_M32K  = 32'h00007fff;
  // Wait counts
  localparam int WAIT_W = 3;
  localparam logic [WAIT_W-1:0] WAIT_ONE = 3'h1;
  typedef enum logic [1:0] {
    HBCW_CYC_IO   = 2'h0,
    HBCW_CYC_MMIO = 2'h1,
    HBCW_CYC_MEM  = 2'h2
  } hbcw_cyc_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DELAY = 3'b010,
    ST_RUN   = 3'b100
  } hbcw_state_t;
endpackage

// *** pkg/hbcw_wait_if.sv ***
/*
  Carrier between the cycle controller and its ready timer.
  Assumes both ends share the host clock.
*/
`timescale 1ns/1ps
interface hbcw_wait_if;
  logic       load;
  logic [2:0] waits;
  logic       ready;
  logic       busy;
  modport ctrl  (output load, output waits, input ready, input busy);
  modport timer (input load, input waits, output ready, output busy);
endinterface

// *** rtl/hbcw_wait_timer.sv ***
/*
  Ready timer: counts the wait clocks of one accepted cycle and then
  pulses ready. Assumes load comes only while the timer is idle.
*/
`timescale 1ns/1ps
module hbcw_wait_timer
  import hbcw_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst,
  hbcw_wait_if.timer w
);
  logic [WAIT_W-1:0] cnt_r;
  logic              busy_r;
  logic              ready_r;

  assign w.ready = ready_r;
  assign w.busy  = busy_r;

  // Ready comes waits+1 clocks after the load cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= '0;
      busy_r  <= 1'b0;
      ready_r <= 1'b0;
    end else begin
      ready_r <= 1'b0;
      if (w.load && !busy_r) begin
        if (w.waits == '0) begin
          ready_r <= 1'b1;
        end else begin
          busy_r <= 1'b1;
          cnt_r  <= w.waits - WAIT_ONE;
        end
      end else if (busy_r) begin
        if (cnt_r == '0) begin
          ready_r <= 1'b1;
          busy_r  <= 1'b0;
        end else begin
          cnt_r <= cnt_r - WAIT_ONE;
        end
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_ready_one_pulse: assert property (ready_r |=> !ready_r)
    else $error("ready held longer than one clock");
  chk_zero_wait_load: assert property (
    w.load && !busy_r && w.waits == '0 |=> ready_r && !busy_r)
    else $error("zero-wait load did not give ready next clock");
endmodule

// *** test/hbcw_host_model.sv ***
/*
  Host bus controller model: starts one host cycle at a time and times
  the ready answer. Assumes the bench calls run_cycle only when idle.
*/
`timescale 1ns/1ps
module hbcw_host_model (
  input  wire logic           REF_CLK,
  output logic                CYC_START,
  output hbcw_pkg::hbcw_cyc_t CYC_TYPE,
  output logic                CYC_WRITE,
  output logic [31:0]         HOST_ADDR,
  output logic [31:0]         MEM_BASE_ADDR,
  output logic [1:0]          GFX_MAP_MODE,
  output logic                MMIO_DECODE,
  input  wire logic           CYC_GO,
  input  wire logic           CYC_BUSY,
  input  wire logic           SLAVE_READY_OUT_N,
  input  wire logic           MEM_CLAIM,
  input  wire logic           MMIO_CLAIM
);
  import hbcw_pkg::*;

  // Quiet bus from time zero
  initial begin
    CYC_START     = 1'b0;
    CYC_TYPE      = HBCW_CYC_IO;
    CYC_WRITE     = 1'b0;
    HOST_ADDR     = 32'h0;
    MEM_BASE_ADDR = 32'h0;
    GFX_MAP_MODE  = 2'h0;
    MMIO_DECODE   = 1'b0;
  end

  // One cycle; lat and go_at count clocks after the start edge, 0 = none
  task automatic run_cycle(input hbcw_cyc_t t, input logic wr,
                           input logic [31:0] a, input logic [31:0] base,
                           input logic [1:0] mode, input logic dec,
                           output int lat, output int go_at,
                           output logic [1:0] clm, output logic bz);
    int n;
    lat = 0;
    go_at = 0;
    clm = 2'h0;
    @(posedge REF_CLK);
    CYC_START     <= 1'b1;
    CYC_TYPE      <= t;
    CYC_WRITE     <= wr;
    HOST_ADDR     <= a;
    MEM_BASE_ADDR <= base;
    GFX_MAP_MODE  <= mode;
    MMIO_DECODE   <= dec;
    @(posedge REF_CLK);
    // Address and type are only valid with the start; scramble them after
    CYC_START <= 1'b0;
    CYC_WRITE <= ~wr;
    HOST_ADDR <= ~a;
    CYC_TYPE  <= hbcw_cyc_t'(~t);
    for (n = 1; n <= 12 && lat == 0; n++) begin
      #1;
      if (CYC_GO === 1'b1 && go_at == 0) go_at = n;
      if (SLAVE_READY_OUT_N === 1'b0) begin
        lat = n;
        clm = {MEM_CLAIM, MMIO_CLAIM};
      end
      @(posedge REF_CLK);
    end
    #1 bz = CYC_BUSY;
  endtask
endmodule

// *** test/tb.sv ***
/*
  Self-checking bench for the register bank: register reads and writes,
  wait timing and response gating against a mirror. Assumes the host
  model sits in host_u and one 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
  import hbcw_pkg::*;
  logic        ref_clk, rst, cfg_wr, cfg_rd, ext_wr, ext_rd;
  logic [7:0]  cfg_addr, ext_index, wr_data, rd_data;
  logic        rd_valid, cyc_start, cyc_write, cyc_go, cyc_busy;
  hbcw_cyc_t   cyc_type;
  logic [31:0] host_addr, mem_base_addr;
  logic [1:0]  gfx_map_mode;
  logic        mmio_decode, ready_n, mem_claim, mmio_claim;
  logic        ext_map_en, isa_mem16, isa_io16;
  logic [7:0]  lb_m, map_m, isa_m, irq_m;
  int          n_errors, cmp_count;
  logic [8:0]  tbl [10] = '{9'h03c, 9'h03d, 9'h03e, 9'h03f, 9'h03b,
                            9'h110, 9'h112, 9'h114, 9'h111, 9'h1ff};

  hbcw_regs dut_u (.REF_CLK(ref_clk), .RST(rst), .CFG_WR(cfg_wr),
    .CFG_RD(cfg_rd), .CFG_ADDR(cfg_addr), .EXT_WR(ext_wr),
    .EXT_RD(ext_rd), .EXT_INDEX(ext_index), .WR_DATA(wr_data),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .CYC_START(cyc_start),
    .CYC_TYPE(cyc_type), .CYC_WRITE(cyc_write), .HOST_ADDR(host_addr),
    .MEM_BASE_ADDR(mem_base_addr), .GFX_MAP_MODE(gfx_map_mode),
    .MMIO_DECODE(mmio_decode), .CYC_GO(cyc_go), .CYC_BUSY(cyc_busy),
    .SLAVE_READY_OUT_N(ready_n), .MEM_CLAIM(mem_claim),
    .MMIO_CLAIM(mmio_claim), .EXT_MAP_EN(ext_map_en),
    .ISA_MEM16(isa_mem16), .ISA_IO16(isa_io16));

  hbcw_host_model host_u (.REF_CLK(ref_clk), .CYC_START(cyc_start),
    .CYC_TYPE(cyc_type), .CYC_WRITE(cyc_write), .HOST_ADDR(host_addr),
    .MEM_BASE_ADDR(mem_base_addr), .GFX_MAP_MODE(gfx_map_mode),
    .MMIO_DECODE(mmio_decode), .CYC_GO(cyc_go), .CYC_BUSY(cyc_busy),
    .SLAVE_READY_OUT_N(ready_n), .MEM_CLAIM(mem_claim),
    .MMIO_CLAIM(mmio_claim));

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  task automatic end_sim();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Mirror back to reset contents
  function automatic void mirror_rst();
    lb_m = LB_WAIT_RST;
    map_m = MEM_MAP_RST;
    isa_m = ISA_WIDTH_RST;
    irq_m = IRQ_ROUTE_RST;
  endfunction

  // Expected read byte; address bit 8 selects the extended space
  function automatic logic [7:0] exp_rd(input logic [8:0] a);
    case (a)
      9'h03c:  return irq_m;
      9'h03d:  return IRQ_PIN_VAL;
      9'h03e:  return MIN_GNT_VAL;
      9'h03f:  return MAX_LAT_VAL;
      9'h110:  return lb_m;
      9'h112:  return isa_m;
      9'h114:  return map_m;
      default: return 8'h00;
    endcase
  endfunction

  // Strobe held over exactly one sampling edge, then released
  task automatic reg_wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cfg_wr <= ~a[8];
    ext_wr <= a[8];
    cfg_addr <= a[7:0];
    ext_index <= a[7:0];
    wr_data <= d;
    @(posedge ref_clk);
    cfg_wr <= 1'b0;
    ext_wr <= 1'b0;
    wr_data <= ~d;
    case (a)
      9'h03c: irq_m = d;
      9'h110: lb_m = d & LB_WAIT_MASK;
      9'h112: isa_m = d & ISA_WIDTH_MASK;
      9'h114: map_m = d & MEM_MAP_MASK;
      default: ;
    endcase
    #1;
  endtask

  task automatic rd_all();
    foreach (tbl[i]) begin
      @(posedge ref_clk);
      cfg_rd <= ~tbl[i][8];
      ext_rd <= tbl[i][8];
      cfg_addr <= tbl[i][7:0];
      ext_index <= tbl[i][7:0];
      @(posedge ref_clk);
      cfg_rd <= 1'b0;
      ext_rd <= 1'b0;
      #1;
      chk(32'(rd_valid), 32'h1);
      chk(32'(rd_data), 32'(exp_rd(tbl[i])));
    end
  endtask

  function automatic logic hit_f(input logic [31:0] a, input logic [31:0] b,
                                 input logic [1:0] mode);
    logic [31:0] base, k;
    base = b;
    if (map_m[0]) begin
      case (map_m[4:2])
        3'h0: k = APER_256K;
        3'h1: k = APER_512K;
        3'h2: k = APER_1M;
        3'h3: k = APER_2M;
        3'h4: k = APER_4M;
        default: return 1'b0;
      endcase
    end else begin
      case (mode)
        2'h0: begin base = LEG_A0000; k = LEG_M128K; end
        2'h1: begin base = LEG_A0000; k = LEG_M64K; end
        2'h2: begin base = LEG_B0000; k = LEG_M32K; end
        default: begin base = LEG_B8000; k = LEG_M32K; end
      endcase
    end
    return (a & ~k) == (base & ~k);
  endfunction

  // Program wait and map registers, run one cycle, check its timing
  task automatic one_cyc(input logic [7:0] lbv, input logic [7:0] mapv,
                         input hbcw_cyc_t t, input logic wr,
                         input logic dec, input logic [31:0] a,
                         input logic [31:0] base, input logic [1:0] mode);
    int lat, go, w;
    logic [1:0] clm;
    logic bz, acc;
    reg_wr(9'h110, lbv);
    reg_wr(9'h114, mapv);
    chk(32'(ext_map_en), 32'(map_m[0]));
    host_u.run_cycle(t, wr, a, base, mode, dec, lat, go, clm, bz);
    acc = t == HBCW_CYC_IO || (t == HBCW_CYC_MMIO && dec && map_m[7]) ||
          (t == HBCW_CYC_MEM && map_m[6] && hit_f(a, base, mode));
    w = t == HBCW_CYC_IO ? lb_m[7:6] + 1 :
        t == HBCW_CYC_MMIO ? lb_m[5:4] + !wr : (wr ? lb_m[2] : 0);
    chk(32'(lat), acc ? 32'(2 + lb_m[0] + w)
                      : 32'h0);
    chk(32'(go), acc ? 32'(1 + lb_m[0]) : 32'h0);
    chk(32'(clm), acc ? {30'h0, t == HBCW_CYC_MEM, t == HBCW_CYC_MMIO}
                      : 32'h0);
    chk(32'(bz), 32'h0);
  endtask

  // Run limit
  initial begin
    #2500000;
    n_errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    logic [31:0] b, a;
    logic [7:0] v;
    ref_clk = 1'b0;
    rst = 1'b1;
    {cfg_wr, cfg_rd, ext_wr, ext_rd} = 4'h0;
    {cfg_addr, ext_index, wr_data} = 24'h0;
    n_errors = 0;
    cmp_count = 0;
    mirror_rst();
    void'($urandom(32'hd0d8));
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({ready_n, cyc_busy}, 32'h2);
    chk({ext_map_en, isa_mem16, isa_io16}, 32'h0);
    rd_all();
    // Every byte, read-only and unmapped ones too, written all ones
    foreach (tbl[i]) reg_wr(tbl[i], 8'hff);
    rd_all();
    for (int i = 0; i < 4; i++) begin
      reg_wr(9'h112, 8'(i << 6));
      chk({isa_mem16, isa_io16}, 32'(i));
    end
    // Corner cycles: reset waits, slowest, boundaries, reserved code
    one_cyc(8'hf5, 8'h40, HBCW_CYC_IO, 1'b0, 1'b0, 32'h0, 32'h0, 2'h0);
    one_cyc(8'h00, 8'h40, HBCW_CYC_MEM, 1'b0, 1'b0, 32'ha0000, 0, 2'h1);
    one_cyc(8'hf5, 8'hc1, HBCW_CYC_MEM, 1'b1, 1'b1, 32'h43ffff,
            32'h400000, 2'h0);
    one_cyc(8'h00, 8'hd1, HBCW_CYC_MEM, 1'b0, 1'b1, 32'h800000,
            32'h400000, 2'h0);
    one_cyc(8'h31, 8'h81, HBCW_CYC_MMIO, 1'b1, 1'b1, 32'h0, 0, 2'h0);
    one_cyc(8'h00, 8'h5d, HBCW_CYC_MEM, 1'b0, 1'b1, 32'h0, 32'h0, 2'h0);
    one_cyc(8'h00, 8'h80, HBCW_CYC_MMIO, 1'b0, 1'b0, 32'h0, 0, 2'h0);
    one_cyc(8'h00, 8'hff, hbcw_cyc_t'(2'h3), 1'b0, 1'b1, 0, 0, 2'h0);
    // Random mix of settings and cycles
    repeat (80) begin
      b = $urandom & 32'hffc00000;
      case ($urandom_range(2, 0))
        0: a = b | ($urandom & 32'h003fffff);
        1: a = 32'h000a0000 | ($urandom & 32'h0001ffff);
        default: a = $urandom;
      endcase
      v = 8'($urandom);
      reg_wr(9'h112, v);
      chk({isa_mem16, isa_io16}, 32'(v[7:6]));
      // Scratch write with its read on the very next edge
      @(posedge ref_clk);
      cfg_wr <= 1'b1;
      cfg_addr <= CFG_IRQ_ROUTE;
      wr_data <= v;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      cfg_rd <= 1'b1;
      @(posedge ref_clk);
      cfg_rd <= 1'b0;
      irq_m = v;
      #1;
      chk(32'(rd_data), 32'(v));
      one_cyc(8'($urandom), 8'($urandom), hbcw_cyc_t'($urandom_range(3, 0)),
              1'($urandom), 1'($urandom), a, b, 2'($urandom));
    end
    // Reset in mid-run brings every register back
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    mirror_rst();
    rd_all();
    end_sim();
  end
endmodule
